// File: ref_ctrl_pkg.sv
// constants for the reference and temperature sense control block
// assumes a plain strobe register port and an 8-bit register
package ref_ctrl_pkg;
	localparam int          DATA_W          = 8;
	localparam int          ADDR_W          = 16;
	localparam logic [15:0] REF_CTRL_ADDR   = 16'h020c;
	localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0210;
	localparam logic [15:0] IRQ_MASK_ADDR   = 16'h0211;
	localparam int          EN_BIT          = 7;
	localparam int          RDY_BIT         = 6;
	localparam int          TS_EN_BIT       = 5;
	localparam int          TS_RNG_BIT      = 4;
	localparam int          CD_GAIN_HI      = 3;
	localparam int          CD_GAIN_LO      = 2;
	localparam int          AD_GAIN_HI      = 1;
	localparam int          AD_GAIN_LO      = 0;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam logic [7:0]  WRITABLE_MASK   = 8'hbf;
	// interrupt status bits: ready rose, ready fell
	localparam int          IRQ_RISE_BIT    = 0;
	localparam int          IRQ_FALL_BIT    = 1;
	localparam logic [1:0]  IRQ_RESET       = 2'h0;
	typedef enum logic [1:0] {
		GAIN_OFF = 2'h0,
		GAIN_X1  = 2'h1,
		GAIN_X2  = 2'h2,
		GAIN_X4  = 2'h3
	} gain_t;
endpackage

// File: gain_if.sv
// decoded buffer gain controls, decoder to top
// assumes one clock domain
`timescale 1ns/10ps
interface gain_if;
	logic       on;
	logic [2:0] onehot;
	modport dec (output on, output onehot);
	modport use_side (input on, input onehot);
endinterface

// File: gain_decode.sv
// decodes a two-bit buffer gain field into on and one-hot gain selects
// assumes the field comes from a register on clk_sys
`timescale 1ns/10ps
module gain_decode (
	// field
	input  wire logic [1:0] gain_field,
	// decoded
	gain_if.dec             dec
);
	always_comb begin
		dec.on     = 1'b1;
		dec.onehot = 3'h0;
		case (ref_ctrl_pkg::gain_t'(gain_field))
			ref_ctrl_pkg::GAIN_X4: dec.onehot = 3'h4;
			ref_ctrl_pkg::GAIN_X2: dec.onehot = 3'h2;
			ref_ctrl_pkg::GAIN_X1: dec.onehot = 3'h1;
			default: dec.on = 1'b0;
		endcase
	end
endmodule

// File: ref_temp_ctrl.sv
// control register bank for the fixed reference and the die temperature sensor
// assumes a one-cycle strobe register port on clk_sys and async analog ready
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
module ref_temp_ctrl #(
	parameter int AW = ref_ctrl_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// register port
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [7:0]    reg_rdata,
	// analog reference
	input  wire logic          ref_ready_async,
	output logic               ref_enable,
	// comparator/DAC buffer
	output logic               cd_buf_on,
	output logic      [2:0]    cd_buf_gain,
	output logic               cd_to_dac,
	output logic               cd_to_cmp,
	output logic               cd_to_adc_channel,
	// ADC buffer
	output logic               ad_buf_on,
	output logic      [2:0]    ad_buf_gain,
	output logic               ad_to_adc_ref,
	output logic               ad_to_adc_channel,
	// temperature sensor
	output logic               temp_sense_enable,
	output logic               temp_range_select,
	// interrupt
	output logic               irq
);

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic       rdy_d;
	logic [1:0] irq_clr;
	logic       irq_d;
	logic       rdy_meta_q;
	logic       rdy_sync_q;
	logic       rdy_prev_q;
	logic       rdy_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_event;
	logic       hit_ctrl;
	logic       hit_stat;
	logic       hit_mask;
	logic [7:0] rdata_d;

	gain_if cd_if ();
	gain_if ad_if ();

	assign hit_ctrl = (reg_addr == AW'(ref_ctrl_pkg::REF_CTRL_ADDR));
	assign hit_stat = (reg_addr == AW'(ref_ctrl_pkg::IRQ_STATUS_ADDR));
	assign hit_mask = (reg_addr == AW'(ref_ctrl_pkg::IRQ_MASK_ADDR));

	// whole-byte write; each field except ready keeps what is written to it
	always_comb begin
		ctrl_d = ctrl_q;
		if (reg_wr && hit_ctrl) begin
			// ready bit never stored; the read path supplies it
			ctrl_d = reg_wdata & ref_ctrl_pkg::WRITABLE_MASK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_q <= ref_ctrl_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// ready synchroniser; first flop feeds only the second
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdy_meta_q <= 1'b0;
			rdy_sync_q <= 1'b0;
		end else begin
			rdy_meta_q <= ref_ready_async;
			rdy_sync_q <= rdy_meta_q;
		end
	end

	// analog may hold ready briefly after disable, so gate with enable
	assign rdy_d = rdy_sync_q & ctrl_q[ref_ctrl_pkg::EN_BIT];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= rdy_d;
		end
	end

	// previous ready for edge events; resets to the idle level, no false edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdy_prev_q <= 1'b0;
		end else begin
			rdy_prev_q <= rdy_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky, write one to clear, set wins
	assign irq_event[ref_ctrl_pkg::IRQ_RISE_BIT] = rdy_q & ~rdy_prev_q;
	assign irq_event[ref_ctrl_pkg::IRQ_FALL_BIT] = ~rdy_q & rdy_prev_q;

	assign irq_clr = (reg_wr && hit_stat) ? reg_wdata[1:0] : 2'h0;

	// one sticky flag per event; a set in the clearing cycle survives
	for (genvar b = 0; b < 2; b++) begin : g_irq_bit
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				irq_stat_q[b] <= ref_ctrl_pkg::IRQ_RESET[b];
			end else if (irq_event[b]) begin
				irq_stat_q[b] <= 1'b1;
			end else if (irq_clr[b]) begin
				irq_stat_q[b] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_mask_q <= ref_ctrl_pkg::IRQ_RESET;
		end else if (reg_wr && hit_mask) begin
			irq_mask_q <= reg_wdata[1:0];
		end
	end

	// level output; costs one cycle so the pin comes from a flop
	assign irq_d = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (hit_ctrl) begin
			rdata_d = ctrl_q;
			rdata_d[ref_ctrl_pkg::RDY_BIT] = rdy_q;
		end else if (hit_stat) begin
			rdata_d = {6'h00, irq_stat_q};
		end else if (hit_mask) begin
			rdata_d = {6'h00, irq_mask_q};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// gain decode
	gain_decode u_cd_dec (
		.gain_field (ctrl_q[ref_ctrl_pkg::CD_GAIN_HI:ref_ctrl_pkg::CD_GAIN_LO]),
		.dec        (cd_if)
	);

	gain_decode u_ad_dec (
		.gain_field (ctrl_q[ref_ctrl_pkg::AD_GAIN_HI:ref_ctrl_pkg::AD_GAIN_LO]),
		.dec        (ad_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// analog controls, all registered
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ref_enable <= 1'b0;
		end else begin
			ref_enable <= ctrl_q[ref_ctrl_pkg::EN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cd_buf_on <= 1'b0;
		end else begin
			cd_buf_on <= cd_if.on;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cd_buf_gain <= 3'h0;
		end else begin
			cd_buf_gain <= cd_if.onehot;
		end
	end

	// buffer two never reaches the converter reference input
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cd_to_dac <= 1'b0;
		end else begin
			cd_to_dac <= cd_if.on;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cd_to_cmp <= 1'b0;
		end else begin
			cd_to_cmp <= cd_if.on;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cd_to_adc_channel <= 1'b0;
		end else begin
			cd_to_adc_channel <= cd_if.on;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ad_buf_on <= 1'b0;
		end else begin
			ad_buf_on <= ad_if.on;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ad_buf_gain <= 3'h0;
		end else begin
			ad_buf_gain <= ad_if.onehot;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ad_to_adc_ref <= 1'b0;
		end else begin
			ad_to_adc_ref <= ad_if.on;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ad_to_adc_channel <= 1'b0;
		end else begin
			ad_to_adc_channel <= ad_if.on;
		end
	end

	// sensor draws nothing while this stays low
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			temp_sense_enable <= 1'b0;
		end else begin
			temp_sense_enable <= ctrl_q[ref_ctrl_pkg::TS_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			temp_range_select <= 1'b0;
		end else begin
			temp_range_select <= ctrl_q[ref_ctrl_pkg::TS_RNG_BIT];
		end
	end

endmodule

// File: ref_temp_ctrl_assertions.sv
// port assertions for the reference control bank
// assumes one clock domain and sync active-low reset
`timescale 1ns/10ps
module ref_temp_ctrl_chk #(
	parameter int AW = 16
) (
	// clock, reset, register port
	input logic          clk_sys,
	input logic          rst_n,
	input logic [AW-1:0] reg_addr,
	input logic [7:0]    reg_wdata,
	input logic          reg_wr,
	input logic          reg_rd,
	input logic [7:0]    reg_rdata,
	// analog controls
	input logic          ref_ready_async,
	input logic          ref_enable,
	input logic          cd_buf_on,
	input logic [2:0]    cd_buf_gain,
	input logic          cd_to_dac,
	input logic          cd_to_cmp,
	input logic          cd_to_adc_channel,
	input logic          ad_buf_on,
	input logic [2:0]    ad_buf_gain,
	input logic          ad_to_adc_ref,
	input logic          ad_to_adc_channel,
	input logic          temp_sense_enable,
	input logic          temp_range_select,
	input logic          irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic wr_c = reg_wr && reg_addr == ref_ctrl_pkg::REF_CTRL_ADDR;
	wire logic rd_c = reg_rd && reg_addr == ref_ctrl_pkg::REF_CTRL_ADDR;
	////////////////////////////////////////
	chk_enable_follows: assert property (wr_c |-> ##2 ref_enable == $past(reg_wdata[7], 2))
		else $error("enable does not follow write");
	chk_cd_gain: assert property (wr_c |-> ##2 cd_buf_gain == 3'((4'h1 << $past(reg_wdata[3:2], 2)) >> 1))
		else $error("cmp dac gain decode wrong");
	chk_ad_gain: assert property (wr_c |-> ##2 ad_buf_gain == 3'((4'h1 << $past(reg_wdata[1:0], 2)) >> 1))
		else $error("adc gain decode wrong");
	chk_cd_route: assert property (cd_to_dac == cd_buf_on && cd_to_cmp == cd_buf_on
		&& cd_to_adc_channel == cd_buf_on && cd_buf_on == (cd_buf_gain != 3'h0))
		else $error("cmp dac routing wrong");
	chk_ad_route: assert property (ad_to_adc_ref == ad_buf_on && ad_to_adc_channel == ad_buf_on
		&& ad_buf_on == (ad_buf_gain != 3'h0))
		else $error("adc routing wrong");
	chk_temp_fields: assert property (wr_c |-> ##2 {temp_sense_enable, temp_range_select} == $past(reg_wdata[5:4], 2))
		else $error("temp fields do not follow write");
	chk_ready_gated: assert property (rd_c && !ref_enable && $past(!ref_enable) |=> !reg_rdata[6])
		else $error("ready read while disabled");
	chk_read_fields: assert property (rd_c |=> reg_rdata[7] == ref_enable
		&& reg_rdata[5:4] == {temp_sense_enable, temp_range_select})
		else $error("readback differs from controls");
	chk_reset_clear: assert property ($rose(rst_n) |-> !ref_enable && !cd_buf_on && !ad_buf_on && !temp_sense_enable)
		else $error("controls not clear after reset");
endmodule

bind ref_temp_ctrl ref_temp_ctrl_chk #(.AW(AW)) chk (.*);

// File: tb_top.sv
// self-checking bench for the reference control bank
// assumes package, interface and design compiled first
`timescale 1ns/10ps
module tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ref_ready_async = 1'b0;
	logic [7:0]  reg_rdata;
	logic        ref_enable, cd_buf_on, cd_to_dac, cd_to_cmp, cd_to_adc_channel;
	logic        ad_buf_on, ad_to_adc_ref, ad_to_adc_channel, temp_sense_enable, temp_range_select, irq;
	logic [2:0]  cd_buf_gain, ad_buf_gain;
	int          fails = 0;
	int          n_checks = 0;
	always #2 clk_sys = ~clk_sys;
	ref_temp_ctrl dut (.*);
	////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// data stands one cycle only, so sample just after the edge
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check(what, exp, reg_rdata);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_gains;
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			d = 8'h80 | 8'(i << 2) | 8'(3 - i);
			wr(ref_ctrl_pkg::REF_CTRL_ADDR, d);
			rd(ref_ctrl_pkg::REF_CTRL_ADDR, d, "ctrl");
			check("cd", {{4{i != 0}}, 1'b0, 3'((4'h1 << i) >> 1)}, {cd_buf_on, cd_to_dac, cd_to_cmp, cd_to_adc_channel, 1'b0, cd_buf_gain});
			check("ad", {{3{i != 3}}, 2'b0, 3'((4'h1 << (3 - i)) >> 1)}, {ad_buf_on, ad_to_adc_ref, ad_to_adc_channel, 2'b0, ad_buf_gain});
			check("en", 8'h01, {7'h0, ref_enable});
		end
		$display("t_gains done");
	endtask
	task automatic t_temp;
		logic [7:0] tv[3] = '{8'h30, 8'h20, 8'h00};
		foreach (tv[k]) begin
			wr(ref_ctrl_pkg::REF_CTRL_ADDR, tv[k]);
			rd(ref_ctrl_pkg::REF_CTRL_ADDR, tv[k], "ctrl");
			check("temp", {5'h0, tv[k][7], tv[k][5:4]}, {5'h0, ref_enable, temp_sense_enable, temp_range_select});
		end
		$display("t_temp done");
	endtask
	task automatic t_ready;
		wr(ref_ctrl_pkg::REF_CTRL_ADDR, 8'hff);
		rd(ref_ctrl_pkg::REF_CTRL_ADDR, 8'hbf, "ro bit");
		wr(16'h0300, 8'h00);
		rd(ref_ctrl_pkg::REF_CTRL_ADDR, 8'hbf, "ctrl kept");
		rd(16'h0300, 8'h00, "unmapped");
		@(posedge clk_sys);
		ref_ready_async <= 1'b1;
		rd(ref_ctrl_pkg::REF_CTRL_ADDR, 8'hbf, "sync delay");
		repeat (4) @(posedge clk_sys);
		rd(ref_ctrl_pkg::REF_CTRL_ADDR, 8'hff, "ready");
		wr(ref_ctrl_pkg::REF_CTRL_ADDR, 8'h3f);
		rd(ref_ctrl_pkg::REF_CTRL_ADDR, 8'h3f, "ready off");
		rd(ref_ctrl_pkg::IRQ_STATUS_ADDR, 8'h03, "status");
		check("irq masked", 8'h00, {7'h0, irq});
		wr(ref_ctrl_pkg::IRQ_MASK_ADDR, 8'h01);
		repeat (3) @(posedge clk_sys);
		check("irq", 8'h01, {7'h0, irq});
		wr(ref_ctrl_pkg::IRQ_STATUS_ADDR, 8'h01);
		rd(ref_ctrl_pkg::IRQ_STATUS_ADDR, 8'h02, "w1c");
		check("irq clear", 8'h00, {7'h0, irq});
		rd(ref_ctrl_pkg::IRQ_MASK_ADDR, 8'h01, "mask");
		$display("t_ready done");
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(ref_ctrl_pkg::REF_CTRL_ADDR, 8'h00, "reset");
		check("outs", 8'h00, {ref_enable, temp_sense_enable, cd_buf_gain, ad_buf_gain});
		t_gains();
		t_temp();
		t_ready();
		final_report();
	end
	// whole run is under a hundred cycles
	initial begin
		repeat (2000) @(posedge clk_sys);
		fails++;
		final_report();
	end
endmodule
